//--- usart_params.svh
`ifndef USART_PARAMS_SVH
`define USART_PARAMS_SVH

// Register byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_CLEAR 8'h08
`define ADDR_TXDATA 8'h0C
`define ADDR_BAUD 8'h10

// Control register fields
`define CTRL_W 12
`define CTRL_TRANSMITTER_ENABLE 0
`define CTRL_RXEN 1
`define CTRL_LEN_LO 2
`define CTRL_LEN_HI 3
`define CTRL_PEN 4
`define CTRL_PODD 5
`define CTRL_STOP_LO 6
`define CTRL_STOP_HI 7
`define CTRL_HALF_DUPLEX_ENABLE 8
`define CTRL_CKEN 9
`define CTRL_PEIE 10
`define CTRL_TCIE 11
`define CTRL_RESET 12'h000

// Status and clear bits
`define ST_TXBE 0
`define ST_TC 1
`define ST_PE 2
`define CLR_PE 0
`define CLR_TC 1

// Character length codes and bit counts
`define LEN_8 2'h0
`define LEN_9 2'h1
`define LEN_7 2'h2
`define CHARS_7 4'h7
`define CHARS_8 4'h8
`define CHARS_9 4'h9

// Stop field codes and their length in half bits
`define STOP_1 2'h0
`define STOP_HALF 2'h1
`define STOP_2 2'h2
`define STOP_1P5 2'h3
`define HALVES_HALF 3'h1
`define HALVES_1 3'h2
`define HALVES_1P5 3'h3
`define HALVES_2 3'h4

// Half-bit period in clock cycles, 115200 baud at 20 MHz
`define BAUD_RESET 16'h0057
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- usart_pkg.sv
`default_nettype none
`include "usart_params.svh"

package usart_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_state_t;

	function automatic logic [3:0] char_bits(input logic [1:0] sel);
		unique case (sel)
			`LEN_9: char_bits = `CHARS_9;
			`LEN_7: char_bits = `CHARS_7;
			default: char_bits = `CHARS_8;
		endcase
	endfunction : char_bits

	// Parity over the bits below the top one of an n-bit character
	function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n,
			input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < 9; i++) begin
			if (4'(i) + 4'h1 < n) begin
				p = p ^ d[i];
			end
		end
		parity_of = p;
	endfunction : parity_of

	function automatic logic [2:0] stop_halves(input logic [1:0] sel);
		unique case (sel)
			`STOP_HALF: stop_halves = `HALVES_HALF;
			`STOP_2: stop_halves = `HALVES_2;
			`STOP_1P5: stop_halves = `HALVES_1P5;
			default: stop_halves = `HALVES_1;
		endcase
	endfunction : stop_halves
endpackage : usart_pkg

`default_nettype wire

//--- half_bit_divider.sv
`default_nettype none
`include "usart_params.svh"

module half_bit_divider (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic clear,
	input wire logic [15:0] div,
	// Half-bit enable pulse
	output logic tick
);
	logic [15:0] cnt_reg;

	// Held in clear so the first half bit is full length
	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			cnt_reg <= 16'h0000;
			tick <= 1'b0;
		end else if ({1'b0, cnt_reg} + 17'h00001 >= {1'b0, div}) begin
			cnt_reg <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule : half_bit_divider

`default_nettype wire

//--- rx_parity_check.sv
`default_nettype none
`include "usart_params.svh"

module rx_parity_check (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Configuration
	input wire logic enable,
	input wire logic [15:0] div,
	input wire logic [1:0] len_sel,
	input wire logic pen,
	input wire logic podd,
	// Serial input and result
	input wire logic line,
	output logic perr
);
	usart_pkg::rx_state_t state_reg;
	logic prev_reg;
	logic half_reg;
	logic [3:0] cnt_reg;
	logic [8:0] data_reg;
	logic tick;
	logic [3:0] n;

	assign n = usart_pkg::char_bits(len_sel);

	half_bit_divider u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(state_reg == usart_pkg::RX_IDLE),
		.div(div),
		.tick(tick)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_reg <= 1'b1;
		end else begin
			prev_reg <= line;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= usart_pkg::RX_IDLE;
			half_reg <= 1'b0;
			cnt_reg <= 4'h0;
			data_reg <= 9'h000;
			perr <= 1'b0;
		end else begin
			perr <= 1'b0;
			unique case (state_reg)
				usart_pkg::RX_IDLE: begin
					if (enable && prev_reg && !line) begin
						state_reg <= usart_pkg::RX_START;
					end
				end
				usart_pkg::RX_START: begin
					// Mid start bit; a high level here was a glitch
					if (tick) begin
						state_reg <= line ? usart_pkg::RX_IDLE : usart_pkg::RX_BITS;
						half_reg <= 1'b0;
						cnt_reg <= 4'h0;
					end
				end
				usart_pkg::RX_BITS: begin
					if (tick) begin
						half_reg <= ~half_reg;
						if (half_reg) begin
							data_reg[cnt_reg] <= line;
							if (cnt_reg + 4'h1 == n) begin
								state_reg <= usart_pkg::RX_STOP;
								perr <= pen && (usart_pkg::parity_of(data_reg, n, podd) != line);
							end else begin
								cnt_reg <= cnt_reg + 4'h1;
							end
						end
					end
				end
				usart_pkg::RX_STOP: begin
					if (line) begin
						state_reg <= usart_pkg::RX_IDLE;
					end
				end
			endcase
		end
	end
endmodule : rx_parity_check

`default_nettype wire

//--- usart_tx_core.sv
// The AXI4-Lite register port and the register offsets were left to the implementer.
`default_nettype none
`include "usart_params.svh"

module usart_tx_core (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Serial pins
	input wire logic rx_i,
	input wire logic tx_i,
	output logic tx_o,
	output logic tx_oe,
	output logic ck_o,
	// Interrupt
	output logic irq
);
	logic [`CTRL_W-1:0] ctrl_reg;
	logic [15:0] baud_reg;
	logic [8:0] buf_reg;
	logic buf_full_reg;
	logic tc_reg;
	logic pe_reg;
	usart_pkg::tx_state_t state_reg;
	logic half_reg;
	logic [3:0] bit_cnt_reg;
	logic [2:0] stop_cnt_reg;
	logic [8:0] shift_reg;
	logic line_reg;
	logic [7:0] aw_addr_reg;
	logic aw_full_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic w_full_reg;

	logic te, hd, pen, podd;
	logic [1:0] len_sel, stop_sel;
	logic [3:0] n;
	logic tick, rx_perr, rx_line;
	logic aw_hs, w_hs, ar_hs, do_write;
	logic aw_full_next, w_full_next, bvalid_next, rvalid_next;
	logic wr_ctrl, wr_clear, wr_tx, wr_baud, wr_ok;
	logic load, frame_end;
	logic [8:0] frame;

	assign te = ctrl_reg[`CTRL_TRANSMITTER_ENABLE];
	assign hd = ctrl_reg[`CTRL_HALF_DUPLEX_ENABLE];
	assign pen = ctrl_reg[`CTRL_PEN];
	assign podd = ctrl_reg[`CTRL_PODD];
	assign len_sel = ctrl_reg[`CTRL_LEN_HI:`CTRL_LEN_LO];
	assign stop_sel = ctrl_reg[`CTRL_STOP_HI:`CTRL_STOP_LO];
	assign n = usart_pkg::char_bits(len_sel);

	// Bus handshakes; write commits once address and data are both held
	assign aw_hs = awvalid && awready;
	assign w_hs = wvalid && wready;
	assign ar_hs = arvalid && arready;
	assign do_write = aw_full_reg && w_full_reg && !bvalid;
	assign aw_full_next = do_write ? 1'b0 : (aw_full_reg || aw_hs);
	assign w_full_next = do_write ? 1'b0 : (w_full_reg || w_hs);
	assign bvalid_next = do_write ? 1'b1 : (bvalid && !bready);
	assign rvalid_next = ar_hs ? 1'b1 : (rvalid && !rready);
	assign wr_ctrl = do_write && aw_addr_reg == `ADDR_CTRL;
	assign wr_clear = do_write && aw_addr_reg == `ADDR_CLEAR && w_strb_reg[0];
	assign wr_tx = do_write && aw_addr_reg == `ADDR_TXDATA && w_strb_reg[0];
	assign wr_baud = do_write && aw_addr_reg == `ADDR_BAUD;
	assign wr_ok = aw_addr_reg == `ADDR_CTRL || aw_addr_reg == `ADDR_CLEAR ||
		aw_addr_reg == `ADDR_TXDATA || aw_addr_reg == `ADDR_BAUD;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			bvalid <= bvalid_next;
			awready <= !aw_full_next && !bvalid_next;
			wready <= !w_full_next && !bvalid_next;
			if (aw_hs) begin
				aw_addr_reg <= awaddr;
			end
			if (w_hs) begin
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
			end
			if (do_write) begin
				bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	// Reads answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `RESP_OKAY;
		end else begin
			rvalid <= rvalid_next;
			arready <= !rvalid_next;
			if (ar_hs) begin
				rresp <= `RESP_OKAY;
				unique case (araddr)
					`ADDR_CTRL: rdata <= {20'h00000, ctrl_reg};
					`ADDR_STATUS: rdata <= {29'h00000000, pe_reg, tc_reg, !buf_full_reg};
					`ADDR_CLEAR: rdata <= 32'h00000000;
					`ADDR_TXDATA: rdata <= {23'h000000, buf_reg};
					`ADDR_BAUD: rdata <= {16'h0000, baud_reg};
					default: begin
						rdata <= 32'h00000000;
						rresp <= `RESP_SLVERR;
					end
				endcase
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= `CTRL_RESET;
			baud_reg <= `BAUD_RESET;
		end else begin
			if (wr_ctrl && w_strb_reg[0]) begin
				ctrl_reg[7:0] <= w_data_reg[7:0];
			end
			if (wr_ctrl && w_strb_reg[1]) begin
				ctrl_reg[`CTRL_W-1:8] <= w_data_reg[`CTRL_W-1:8];
			end
			if (wr_baud && w_strb_reg[0]) begin
				baud_reg[7:0] <= w_data_reg[7:0];
			end
			if (wr_baud && w_strb_reg[1]) begin
				baud_reg[15:8] <= w_data_reg[15:8];
			end
		end
	end

	always_comb begin
		frame = buf_reg;
		if (pen) begin
			frame[n - 4'h1] = usart_pkg::parity_of(buf_reg, n, podd);
		end
	end

	assign load = state_reg == usart_pkg::TX_IDLE && te && buf_full_reg;
	assign frame_end = state_reg == usart_pkg::TX_STOP && tick && stop_cnt_reg == 3'h1;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			buf_reg <= 9'h000;
			buf_full_reg <= 1'b0;
		end else if (wr_tx) begin
			buf_reg <= w_data_reg[8:0];
			buf_full_reg <= 1'b1;
		end else if (load) begin
			buf_full_reg <= 1'b0;
		end
	end

	half_bit_divider u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(state_reg == usart_pkg::TX_IDLE),
		.div(baud_reg),
		.tick(tick)
	);

	// A started frame always finishes, even if the enable drops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= usart_pkg::TX_IDLE;
			half_reg <= 1'b0;
			bit_cnt_reg <= 4'h0;
			stop_cnt_reg <= 3'h0;
			shift_reg <= 9'h000;
			line_reg <= 1'b1;
		end else begin
			unique case (state_reg)
				usart_pkg::TX_IDLE: begin
					line_reg <= 1'b1;
					half_reg <= 1'b0;
					if (load) begin
						state_reg <= usart_pkg::TX_START;
						shift_reg <= frame;
						line_reg <= 1'b0;
					end
				end
				usart_pkg::TX_START: begin
					if (tick) begin
						half_reg <= ~half_reg;
						if (half_reg) begin
							state_reg <= usart_pkg::TX_DATA;
							line_reg <= shift_reg[0];
							shift_reg <= shift_reg >> 1;
							bit_cnt_reg <= n;
						end
					end
				end
				usart_pkg::TX_DATA: begin
					if (tick) begin
						half_reg <= ~half_reg;
						if (half_reg && bit_cnt_reg == 4'h1) begin
							state_reg <= usart_pkg::TX_STOP;
							line_reg <= 1'b1;
							stop_cnt_reg <= usart_pkg::stop_halves(stop_sel);
						end else if (half_reg) begin
							line_reg <= shift_reg[0];
							shift_reg <= shift_reg >> 1;
							bit_cnt_reg <= bit_cnt_reg - 4'h1;
						end
					end
				end
				usart_pkg::TX_STOP: begin
					line_reg <= 1'b1;
					if (tick) begin
						stop_cnt_reg <= stop_cnt_reg - 3'h1;
						if (stop_cnt_reg == 3'h1) begin
							state_reg <= usart_pkg::TX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Sticky flags; a setting event beats a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tc_reg <= 1'b1;
			pe_reg <= 1'b0;
		end else begin
			if (frame_end && !buf_full_reg) begin
				tc_reg <= 1'b1;
			end else if (wr_tx || (wr_clear && w_data_reg[`CLR_TC])) begin
				tc_reg <= 1'b0;
			end
			if (rx_perr) begin
				pe_reg <= 1'b1;
			end else if (wr_clear && w_data_reg[`CLR_PE]) begin
				pe_reg <= 1'b0;
			end
		end
	end

	// receiver hears the TX line in half duplex
	assign rx_line = hd ? tx_i : rx_i;

	rx_parity_check u_rx (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(ctrl_reg[`CTRL_RXEN]),
		.div(baud_reg),
		.len_sel(len_sel),
		.pen(pen),
		.podd(podd),
		.line(rx_line),
		.perr(rx_perr)
	);

	// Pins lag the frame by one cycle so every output is a flop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_o <= 1'b1;
			tx_oe <= 1'b0;
			ck_o <= 1'b0;
			irq <= 1'b0;
		end else begin
			tx_o <= hd ? 1'b0 : line_reg;
			tx_oe <= hd ? !line_reg : (te || state_reg != usart_pkg::TX_IDLE);
			ck_o <= ctrl_reg[`CTRL_CKEN] && state_reg == usart_pkg::TX_DATA && half_reg;
			irq <= (pe_reg && pen && ctrl_reg[`CTRL_PEIE]) || (tc_reg && ctrl_reg[`CTRL_TCIE]);
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_idle_high;
		state_reg == usart_pkg::TX_IDLE && !load |=> line_reg;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("idle line not high");

	property p_start_low;
		load |=> state_reg == usart_pkg::TX_START && !line_reg ##1 !tx_o || hd;
	endproperty
	a_start_low: assert property (p_start_low) else $error("start bit not low");

	property p_stop_high;
		state_reg == usart_pkg::TX_STOP |-> line_reg;
	endproperty
	a_stop_high: assert property (p_stop_high) else $error("stop bit not high");

	property p_write_fills;
		wr_tx |=> buf_full_reg && (!tc_reg || $past(frame_end && !buf_full_reg));
	endproperty
	a_write_fills: assert property (p_write_fills) else $error("write did not fill");

	property p_load_empties;
		load && !wr_tx |=> !buf_full_reg && shift_reg == $past(frame);
	endproperty
	a_load_empties: assert property (p_load_empties) else $error("load failed");

	property p_complete;
		frame_end && !buf_full_reg |=> tc_reg && state_reg == usart_pkg::TX_IDLE;
	endproperty
	a_complete: assert property (p_complete) else $error("complete not set");

	property p_parity_sticky;
		rx_perr |=> pe_reg ##1 (pe_reg || $past(wr_clear));
	endproperty
	a_parity_sticky: assert property (p_parity_sticky) else $error("parity flag lost");

	property p_open_drain;
		hd && $past(hd) |-> !tx_o && tx_oe == !$past(line_reg);
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("half duplex not open drain");

	property p_lsb_first;
		state_reg == usart_pkg::TX_START && tick && half_reg |=> line_reg == $past(shift_reg[0]);
	endproperty
	a_lsb_first: assert property (p_lsb_first) else $error("first bit not LSB");

	property p_stop_len;
		state_reg == usart_pkg::TX_DATA && tick && half_reg && bit_cnt_reg == 4'h1
			|=> stop_cnt_reg == usart_pkg::stop_halves(stop_sel);
	endproperty
	a_stop_len: assert property (p_stop_len) else $error("stop length wrong");

	c_parity_frame: cover property (load && pen && len_sel == `LEN_7);
	c_stop_1p5: cover property (frame_end && stop_sel == `STOP_1P5);
	c_back_to_back: cover property (frame_end && buf_full_reg);
	c_parity_error: cover property (rx_perr && hd);
endmodule : usart_tx_core

`default_nettype wire

//--- serial_peer.sv
`default_nettype none

module serial_peer (
	// Clock
	input wire logic aclk,
	// Observed pins
	input wire logic line_lvl,
	input wire logic ck_pin,
	// Half-bit time in clock cycles and character bits
	input var int half,
	input var int nbits,
	// Driven pins
	output logic rx_line,
	output logic pull_low
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] words[$];
	int starts[$];
	logic stops[$];
	int cyc = 0;
	int ck_count = 0;
	logic sending = 1'b0;
	logic prev = 1'b1;
	logic ck_prev = 1'b0;
	logic [8:0] w;

	initial begin
		rx_line = 1'b1;
		pull_low = 1'b0;
	end

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		ck_prev <= ck_pin;
		if (ck_pin && !ck_prev) begin
			ck_count <= ck_count + 1;
		end
	end

	// Own frames on the shared wire are not captured
	always begin
		@(posedge aclk);
		if (prev && !line_lvl && !sending) begin
			starts.push_back(cyc);
			repeat (half) @(posedge aclk);
			w = 9'h000;
			for (int i = 0; i < nbits; i++) begin
				repeat (2 * half) @(posedge aclk);
				w[i] = line_lvl;
			end
			// Early stop sample so a half stop bit is still caught
			repeat (half + half / 2) @(posedge aclk);
			stops.push_back(line_lvl);
			words.push_back(w);
		end
		prev = line_lvl;
	end

	task automatic send(input logic [8:0] d, input int n, input logic on_line);
		logic b;
		sending = 1'b1;
		for (int i = 0; i <= n + 1; i++) begin
			b = (i == 0) ? 1'b0 : (i > n) ? 1'b1 : d[i - 1];
			if (on_line) begin
				pull_low <= !b;
			end else begin
				rx_line <= b;
			end
			repeat (2 * half) @(posedge aclk);
		end
		pull_low <= 1'b0;
		rx_line <= 1'b1;
		sending = 1'b0;
	endtask : send
endmodule : serial_peer

`default_nettype wire

//--- tb_usart_tx_core.sv
`default_nettype none
`include "usart_params.svh"

module tb_usart_tx_core;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, tx_o, tx_oe, ck_o, irq;
	logic rx_line, pull_low, tx_wire;
	logic [1:0] bresp, rresp;
	logic [15:0] seed = 16'h3EF0;
	// clock output never with half duplex
	logic [7:0] cfgs[8] = '{8'h00, 8'h25, 8'h78, 8'hAD, 8'h88, 8'h41, 8'h3C, 8'h0A};
	int nb[4] = '{8, 9, 7, 8};
	int hvs[4] = '{2, 1, 4, 3};
	int half = 4, nbits = 8, bad_count = 0, checks = 0;

	// Pulled up when nobody drives
	assign tx_wire = (tx_oe ? tx_o : 1'b1) & ~pull_low;
	always #25 aclk = ~aclk;

	usart_tx_core usart_tx_core_i (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .rx_i(rx_line), .tx_i(tx_wire), .tx_o(tx_o),
		.tx_oe(tx_oe), .ck_o(ck_o), .irq(irq));
	serial_peer serial_peer_i (.aclk(aclk), .line_lvl(tx_wire), .ck_pin(ck_o), .half(half),
		.nbits(nbits), .rx_line(rx_line), .pull_low(pull_low));

	function automatic logic [15:0] lfsr();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction : lfsr

	function automatic logic [8:0] exp_word(input logic [8:0] d, input int n,
			input logic pen, input logic odd);
		logic [8:0] w;
		logic p;
		w = 9'h000;
		p = odd;
		for (int i = 0; i < n; i++) w[i] = d[i];
		if (pen) begin
			for (int i = 0; i < n - 1; i++) p = p ^ d[i];
			w[n - 1] = p;
		end
		return w;
	endfunction : exp_word

	function automatic logic [31:0] ctrl(input logic te, re, input logic [1:0] len,
			input logic pen, odd, input logic [1:0] stp, input logic hd, ck, peie, tcie);
		return 32'({tcie, peie, ck, hd, stp, odd, pen, len, re, te});
	endfunction : ctrl

	task automatic conclude();
		if (bad_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude

	task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : check_val

	task automatic check_pin(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask : check_pin

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		// Idle edge so a following call never re-raises bready at once
		@(posedge aclk);
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_read

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_write(a, d, r);
		check_val("bresp", `RESP_OKAY, 32'(r));
	endtask : wr

	task automatic rd_check(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(a, d, r);
		check_val(nm, e, d);
	endtask : rd_check

	task automatic rx_case(input logic on_line, input logic odd, input logic bad, input logic pe);
		logic [31:0] d;
		logic [1:0] r;
		logic [8:0] w;
		w = exp_word(9'(lfsr()), 8, 1'b1, odd);
		w[7] = w[7] ^ bad;
		serial_peer_i.send(w, 8, on_line);
		repeat (4) @(posedge aclk);
		axi_read(`ADDR_STATUS, d, r);
		@(posedge aclk);
		check_pin("parity flag", pe, d[2]);
		check_pin("parity irq", pe, irq);
	endtask : rx_case

	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		conclude();
	end

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [8:0] cs[2];
		logic [7:0] cf;
		int n, hv, k;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_check(`ADDR_CTRL, 32'h0, "ctrl reset");
		rd_check(`ADDR_STATUS, 32'h3, "status reset");
		rd_check(`ADDR_BAUD, 32'h57, "baud reset");
		rd_check(`ADDR_CLEAR, 32'h0, "clear reads");
		axi_read(8'h14, d, r);
		check_val("unmapped rdata", 32'h0, d);
		check_val("unmapped rresp", `RESP_SLVERR, 32'(r));
		axi_write(8'h14, 32'hFFFF_FFFF, r);
		check_val("unmapped bresp", `RESP_SLVERR, 32'(r));
		wr(`ADDR_BAUD, 32'(half));
		for (int i = 0; i < 8; i++) begin
			cf = cfgs[i];
			n = nb[cf[7:6]];
			hv = hvs[cf[3:2]];
			nbits = n;
			wr(`ADDR_CTRL, ctrl(1, 0, cf[7:6], cf[5], cf[4], cf[3:2], cf[1], cf[0], 0, i[0]));
			k = serial_peer_i.ck_count;
			cs[0] = 9'(lfsr());
			cs[1] = 9'(lfsr());
			wr(`ADDR_TXDATA, 32'(cs[0]));
			rd_check(`ADDR_STATUS, 32'h1, "status first load");
			wr(`ADDR_TXDATA, 32'(cs[1]));
			rd_check(`ADDR_STATUS, 32'h0, "status buffer full");
			do axi_read(`ADDR_STATUS, d, r); while (d[1] !== 1'b1);
			@(posedge aclk);
			check_val("status done", 32'h3, d);
			check_pin("complete irq", i[0], irq);
			check_val("frame count", 32'h2, 32'(serial_peer_i.words.size()));
			for (int j = 0; j < 2; j++) begin
				check_val("frame", 32'(exp_word(cs[j], n, cf[5], cf[4])),
					32'(serial_peer_i.words[j]));
				check_pin("stop level", 1'b1, serial_peer_i.stops[j]);
			end
			// Start bit is one cycle longer as the divider restarts from idle
			check_val("frame spacing", 32'((1 + n) * 2 * half + hv * half + 2),
				32'(serial_peer_i.starts[1] - serial_peer_i.starts[0]));
			check_val("clock pulses", cf[0] ? 32'(2 * n) : 32'h0,
				32'(serial_peer_i.ck_count - k));
			check_pin("idle line", 1'b1, tx_wire);
			check_pin("tx value", !cf[1], tx_o);
			check_pin("tx enable", !cf[1], tx_oe);
			serial_peer_i.words.delete();
			serial_peer_i.stops.delete();
			serial_peer_i.starts.delete();
			wr(`ADDR_CLEAR, 32'h2);
			@(posedge aclk);
			check_pin("irq cleared", 1'b0, irq);
		end
		nbits = 8;
		wr(`ADDR_CTRL, ctrl(0, 1, `LEN_8, 1, 0, `STOP_1, 0, 0, 1, 0));
		rx_case(1'b0, 1'b0, 1'b0, 1'b0);
		rx_case(1'b0, 1'b0, 1'b1, 1'b1);
		rx_case(1'b0, 1'b0, 1'b0, 1'b1);
		wr(`ADDR_CLEAR, 32'h1);
		rd_check(`ADDR_STATUS, 32'h1, "parity cleared");
		wr(`ADDR_CTRL, ctrl(1, 0, `LEN_8, 1, 1, `STOP_1, 1, 0, 1, 0));
		wr(`ADDR_TXDATA, 32'(lfsr()));
		do axi_read(`ADDR_STATUS, d, r); while (d[1] !== 1'b1);
		wr(`ADDR_CTRL, ctrl(0, 1, `LEN_8, 1, 1, `STOP_1, 1, 0, 1, 0));
		rx_case(1'b0, 1'b1, 1'b1, 1'b0);
		rx_case(1'b1, 1'b1, 1'b1, 1'b1);
		conclude();
	end
endmodule : tb_usart_tx_core

`default_nettype wire
